// [aid_detector.sv]
/*
  Activity/inactivity detector: slope per axis, threshold compare, duration
  counters, rate override, event pulses, pin routing and a register port.
  Assumes one clock, a one-cycle sample tick carrying fresh X/Y/Z samples, and
  a host that uses single-cycle read/write strobes.
*/
// Chosen here: the plain strobed port and the placing of the registers.
// Function
// RULE1: Detection runs only while the sleep-detect enable bit of the threshold register is 1.
// RULE2: Each axis slope is half of the current sample minus the previous sample.
// RULE3: The wake threshold is a 6-bit unsigned field worth full scale over 64 per step.
// RULE4: Slope magnitude is compared, so both signs behave alike.
// RULE5: All axes quiet for the sleep time enters inactivity and forces the fixed low rate.
// RULE6: The quiet-duration field is 4 bits, each step 512 sample periods.
// RULE7: Entering inactivity pulses the event for exactly one sample period.
// RULE8: While inactive, one axis above threshold for the wake time restores the set rate.
// RULE9: The activity-duration field is 2 bits, each step one sample period.
// RULE10: Returning to activity pulses the event for one sample period.
// RULE11: The override acts on the accelerometer rate only, never the gyroscope.
// RULE12: The state routes to either interrupt pin by its routing bit and reads as a flag.
// RULE13: Each duration counter restarts whenever a sample breaks its condition.
`timescale 1ns/1ps
`include "aid_defines.svh"

module aid_detector (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic signed [`AID_ACC_W-1:0] acc_x,
  input wire logic signed [`AID_ACC_W-1:0] acc_y,
  input wire logic signed [`AID_ACC_W-1:0] acc_z,
  input wire logic [3:0] gyro_rate_in,
  input wire logic [`AID_ADDR_W-1:0] reg_addr,
  input wire logic [`AID_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`AID_DATA_W-1:0] reg_rdata,
  output logic [3:0] accel_rate_out,
  output logic [3:0] gyro_rate_out,
  output logic irq_pin_one,
  output logic irq_pin_two,
  output logic event_pulse,
  output logic irq
);

  // Magnitude of half the difference of two samples
  function automatic logic [`AID_ACC_W-1:0] slope_mag(
    input logic signed [`AID_ACC_W-1:0] cur,
    input logic signed [`AID_ACC_W-1:0] prev
  );
    logic signed [`AID_ACC_W:0] diff;
    logic signed [`AID_ACC_W:0] half;
    diff = {cur[`AID_ACC_W-1], cur} - {prev[`AID_ACC_W-1], prev};
    half = diff >>> 1;
    slope_mag = half[`AID_ACC_W] ? `AID_ACC_W'(-half) : half[`AID_ACC_W-1:0];
  endfunction

  function automatic logic addr_is(input logic [`AID_ADDR_W-1:0] a,
                                   input logic [`AID_ADDR_W-1:0] off);
    addr_is = (a == off);
  endfunction

  logic [`AID_DATA_W-1:0] accel_control_reg_r;
  logic [`AID_DATA_W-1:0] wake_threshold_reg_r;
  logic [`AID_DATA_W-1:0] wake_duration_reg_r;
  logic [`AID_DATA_W-1:0] pin1_function_routing_r;
  logic [`AID_DATA_W-1:0] pin2_function_routing_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic signed [`AID_ACC_W-1:0] prev_r [3];
  logic primed_r;
  logic [`AID_QUIET_CNT_W+3:0] quiet_cnt_r;
  logic [`AID_ACT_CNT_W:0] act_cnt_r;
  aid_pkg::aid_state_e state_r;
  aid_pkg::aid_state_e state_nxt;

  wire logic signed [`AID_ACC_W-1:0] cur [3];
  assign cur[0] = acc_x;
  assign cur[1] = acc_y;
  assign cur[2] = acc_z;

  wire logic enable = wake_threshold_reg_r[`AID_SLEEP_EN_BIT];
  wire logic [5:0] wake_threshold_field = wake_threshold_reg_r[`AID_THS_MSB:`AID_THS_LSB];
  wire logic [3:0] quiet_duration_field =
    wake_duration_reg_r[`AID_QUIET_DUR_MSB:`AID_QUIET_DUR_LSB];
  wire logic [1:0] activity_duration_field =
    wake_duration_reg_r[`AID_ACT_DUR_MSB:`AID_ACT_DUR_LSB];
  wire logic [3:0] accel_output_rate = accel_control_reg_r[`AID_RATE_MSB:`AID_RATE_LSB];
  wire logic [1:0] accel_full_scale = accel_control_reg_r[`AID_FS_MSB:`AID_FS_LSB];

  // Threshold in sample LSBs: step is full scale / 64; full scale doubles per code
  wire logic [`AID_ACC_W+3:0] ths_lsb =
    {14'h0000, wake_threshold_field} << (`AID_SHIFT_FS + accel_full_scale); // [RULE3]

  wire logic [2:0] above;
  wire logic [2:0] below;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      wire logic [`AID_ACC_W-1:0] mag = slope_mag(cur[g], prev_r[g]); // [RULE2] [RULE4]
      assign above[g] = {4'h0, mag} > ths_lsb;
      assign below[g] = {4'h0, mag} < ths_lsb;
      always_ff @(posedge clk) begin
        if (rst) begin
          prev_r[g] <= '0;
        end else if (sample_tick) begin
          prev_r[g] <= cur[g];
        end
      end
    end
  endgenerate

  wire logic all_below = &below;
  wire logic any_above = |above;
  wire logic valid_sample = sample_tick && primed_r && enable; // [RULE1]
  wire logic [`AID_QUIET_CNT_W+3:0] quiet_target =
    {9'h000, quiet_duration_field} * {4'h0, `AID_QUIET_STEP}; // [RULE6]
  wire logic [`AID_QUIET_CNT_W+3:0] quiet_inc = quiet_cnt_r + 1'b1;
  wire logic [`AID_ACT_CNT_W:0] act_inc = act_cnt_r + 1'b1;
  wire logic go_inactive = valid_sample && state_r == aid_pkg::AID_ACTIVE && all_below &&
                           quiet_inc >= quiet_target; // [RULE5]
  wire logic go_active = valid_sample && state_r == aid_pkg::AID_INACTIVE && any_above &&
                         act_inc >= {1'b0, activity_duration_field}; // [RULE8] [RULE9]
  wire logic sleep_state_flag = (state_r == aid_pkg::AID_INACTIVE);
  wire logic [1:0] events = {go_active, go_inactive};
  wire logic [1:0] clr_bits = (reg_wr && addr_is(reg_addr, `AID_OFF_IRQ_STATUS)) ?
                              reg_wdata[1:0] : 2'h0;
  wire logic [7:0] wake_source_reg = {3'h0, sleep_state_flag, 4'h0}; // [RULE12]
  wire logic [`AID_DATA_W-1:0] rd_mux =
    addr_is(reg_addr, `AID_OFF_ACCEL_CTRL) ? accel_control_reg_r :
    addr_is(reg_addr, `AID_OFF_WAKE_THS) ? wake_threshold_reg_r :
    addr_is(reg_addr, `AID_OFF_DUR_CFG) ? wake_duration_reg_r :
    addr_is(reg_addr, `AID_OFF_PIN1_ROUTE) ? pin1_function_routing_r :
    addr_is(reg_addr, `AID_OFF_PIN2_ROUTE) ? pin2_function_routing_r :
    addr_is(reg_addr, `AID_OFF_WAKE_SRC) ? wake_source_reg :
    addr_is(reg_addr, `AID_OFF_IRQ_STATUS) ? {6'h00, irq_status_r} :
    addr_is(reg_addr, `AID_OFF_IRQ_MASK) ? {6'h00, irq_mask_r} :
    addr_is(reg_addr, `AID_OFF_EFF_RATE) ? {4'h0, accel_rate_out} : `AID_RST_REG;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      aid_pkg::AID_ACTIVE: begin
        if (go_inactive) begin
          state_nxt = aid_pkg::AID_INACTIVE;
        end
      end
      aid_pkg::AID_INACTIVE: begin
        if (!enable || go_active) begin
          state_nxt = aid_pkg::AID_ACTIVE;
        end
      end
      default: state_nxt = aid_pkg::AID_ACTIVE;
    endcase
  end

  // Write decode, one strobe per writable register
  wire logic wr_accel_ctrl = reg_wr && addr_is(reg_addr, `AID_OFF_ACCEL_CTRL);
  wire logic wr_wake_ths = reg_wr && addr_is(reg_addr, `AID_OFF_WAKE_THS);
  wire logic wr_durations = reg_wr && addr_is(reg_addr, `AID_OFF_DUR_CFG);
  wire logic wr_pin1_route = reg_wr && addr_is(reg_addr, `AID_OFF_PIN1_ROUTE);
  wire logic wr_pin2_route = reg_wr && addr_is(reg_addr, `AID_OFF_PIN2_ROUTE);
  wire logic wr_irq_mask = reg_wr && addr_is(reg_addr, `AID_OFF_IRQ_MASK);

  // Register port; writes to unmapped or read-only offsets are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      accel_control_reg_r <= `AID_RST_REG;
    end else if (wr_accel_ctrl) begin
      accel_control_reg_r <= reg_wdata;
    end
  end

  // Clearing the enable bit drops back to active without an event
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_threshold_reg_r <= `AID_RST_REG;
    end else if (wr_wake_ths) begin
      wake_threshold_reg_r <= reg_wdata; // [RULE1]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_duration_reg_r <= `AID_RST_REG;
    end else if (wr_durations) begin
      wake_duration_reg_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin1_function_routing_r <= `AID_RST_REG;
    end else if (wr_pin1_route) begin
      pin1_function_routing_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin2_function_routing_r <= `AID_RST_REG;
    end else if (wr_pin2_route) begin
      pin2_function_routing_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_r <= 2'h0;
    end else if (wr_irq_mask) begin
      irq_mask_r <= reg_wdata[1:0];
    end
  end

  // Read data stands only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `AID_RST_REG;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `AID_RST_REG;
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_status_r <= (irq_status_r & ~clr_bits) | events;
      irq <= |(((irq_status_r & ~clr_bits) | events) & irq_mask_r);
    end
  end

  // First tick after enable only seeds the previous samples
  always_ff @(posedge clk) begin
    if (rst) begin
      primed_r <= 1'b0;
    end else if (!enable) begin
      primed_r <= 1'b0;
    end else if (sample_tick) begin
      primed_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      quiet_cnt_r <= '0;
      act_cnt_r <= '0;
    end else if (valid_sample) begin
      quiet_cnt_r <= (all_below && state_r == aid_pkg::AID_ACTIVE && !go_inactive) ?
                     quiet_inc : '0; // [RULE13]
      act_cnt_r <= (any_above && state_r == aid_pkg::AID_INACTIVE && !go_active) ?
                   act_inc : '0; // [RULE13]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= aid_pkg::AID_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pulse held from the detecting tick to the next tick: one sample period
  always_ff @(posedge clk) begin
    if (rst) begin
      event_pulse <= 1'b0;
    end else if (go_inactive || go_active) begin
      event_pulse <= 1'b1; // [RULE7] [RULE10]
    end else if (sample_tick) begin
      event_pulse <= 1'b0;
    end
  end

  // The stored rate field is never touched; only the effective rate is overridden
  always_ff @(posedge clk) begin
    if (rst) begin
      accel_rate_out <= `AID_RST_RATE;
    end else begin
      accel_rate_out <= (state_nxt == aid_pkg::AID_INACTIVE) ?
                        `AID_RATE_LOW : accel_output_rate; // [RULE5] [RULE8]
    end
  end

  // Gyroscope rate passes straight through, whatever the detector state
  always_ff @(posedge clk) begin
    if (rst) begin
      gyro_rate_out <= `AID_RST_RATE;
    end else begin
      gyro_rate_out <= gyro_rate_in; // [RULE11]
    end
  end

  // Pins carry the state level, not the event pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pin_one <= 1'b0;
      irq_pin_two <= 1'b0;
    end else begin
      irq_pin_one <= pin1_function_routing_r[`AID_ROUTE_BIT] &&
                     state_nxt == aid_pkg::AID_INACTIVE; // [RULE12]
      irq_pin_two <= pin2_function_routing_r[`AID_ROUTE_BIT] &&
                     state_nxt == aid_pkg::AID_INACTIVE; // [RULE12]
    end
  end

endmodule

// [aid_defines.svh]
/*
  Register offsets, field positions, reset values and timing constants for the
  activity/inactivity detector.
  Assumes inclusion by bare name from design and verification files.
*/
`ifndef AID_DEFINES_SVH
`define AID_DEFINES_SVH

`define AID_ADDR_W 4
`define AID_DATA_W 8
`define AID_ACC_W 16

// Register offsets
`define AID_OFF_ACCEL_CTRL 4'h0
`define AID_OFF_WAKE_THS 4'h1
`define AID_OFF_DUR_CFG 4'h2
`define AID_OFF_PIN1_ROUTE 4'h3
`define AID_OFF_PIN2_ROUTE 4'h4
`define AID_OFF_WAKE_SRC 4'h5
`define AID_OFF_IRQ_STATUS 4'h6
`define AID_OFF_IRQ_MASK 4'h7
`define AID_OFF_EFF_RATE 4'h8

// Field positions
`define AID_THS_LSB 0
`define AID_THS_MSB 5
`define AID_SLEEP_EN_BIT 6
`define AID_ACT_DUR_LSB 5
`define AID_ACT_DUR_MSB 6
`define AID_QUIET_DUR_LSB 0
`define AID_QUIET_DUR_MSB 3
`define AID_ROUTE_BIT 7
`define AID_SLEEP_FLAG_BIT 4
`define AID_RATE_LSB 4
`define AID_RATE_MSB 7
`define AID_FS_LSB 2
`define AID_FS_MSB 3
`define AID_STAT_INACT_BIT 0
`define AID_STAT_ACT_BIT 1

// Reset values
`define AID_RST_REG 8'h00
`define AID_RST_RATE 4'h0

// Fixed low rate code used while inactive
`define AID_RATE_LOW 4'h1

// Quiet step in sample periods, and the quiet counter width minus four bits
`define AID_QUIET_STEP 13'h0200
`define AID_QUIET_CNT_W 13
`define AID_ACT_CNT_W 2
// Slope magnitude bits above the threshold field
`define AID_SHIFT_FS 10

`endif

// [aid_pkg.sv]
/*
  Types for the activity/inactivity detector.
  Assumes aid_defines.svh is compiled alongside.
*/
package aid_pkg;
  typedef enum logic {AID_ACTIVE, AID_INACTIVE} aid_state_e;
endpackage

// [aid_detector_asserts.sv]
/* Checker on the detector ports.
   Assumes a bind onto aid_detector, one clock, rst synchronous. */
`timescale 1ns/1ps
`include "aid_defines.svh"
module aid_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic [3:0] gyro_rate_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`AID_DATA_W-1:0] reg_rdata,
  input wire logic [3:0] accel_rate_out,
  input wire logic [3:0] gyro_rate_out,
  input wire logic irq_pin_one,
  input wire logic irq_pin_two,
  input wire logic event_pulse,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pulse_end;
    $fell(event_pulse);
  endsequence
  // State outputs move only after a tick or a write
  property p_caused(logic e);
    e |-> $past(sample_tick) || $past(sample_tick, 2) || $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_gyro_untouched:
    assert property (!$past(rst) |-> gyro_rate_out == $past(gyro_rate_in))
    else $error("gyro rate altered");
  a_pulse_starts:
    assert property ($rose(event_pulse) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("pulse rose without tick");
  a_pulse_ends:
    assert property (s_pulse_end |-> $past(sample_tick) || $past(sample_tick, 2) || $past(reg_wr, 2))
    else $error("pulse fell without tick");
  a_pin_low_rate:
    assert property (irq_pin_one || irq_pin_two |-> accel_rate_out == `AID_RATE_LOW)
    else $error("pin high at full rate");
  a_pin_rise:
    assert property (p_caused($rose(irq_pin_one)))
    else $error("pin rose without cause");
  a_rate_moves:
    assert property (p_caused($changed(accel_rate_out)))
    else $error("rate moved without cause");
  a_irq_rise:
    assert property (p_caused($rose(irq)))
    else $error("irq rose without cause");
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
endmodule

bind aid_detector aid_chk i_chk (.clk, .rst, .sample_tick, .gyro_rate_in, .reg_wr, .reg_rd,
  .reg_rdata, .accel_rate_out, .gyro_rate_out, .irq_pin_one, .irq_pin_two, .event_pulse, .irq);

// [aid_host.sv]
/* Host model: register master with one-cycle strobes.
   Assumes the detector answers a read in the next cycle and never stalls. */
`timescale 1ns/1ps
module aid_host (
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Pin routing bits are set through this write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// [aid_detector_tb_top.sv]
/* Testbench: samples and register traffic against a reference model.
   Assumes aid_host and aid_chk are compiled first. */
`timescale 1ns/1ps
`include "aid_defines.svh"
module aid_detector_tb_top;
  logic clk;
  logic rst = 1'b1;
  logic sample_tick = 1'b0;
  logic signed [15:0] acc_x = 16'h0000, acc_y = 16'h0000, acc_z = 16'h0000;
  logic [3:0] gyro_rate_in = 4'h0, reg_addr, accel_rate_out, gyro_rate_out, rt = 4'h0;
  logic [7:0] reg_wdata, reg_rdata, d, sts = 8'h00, rg [16] = '{default: 8'h00};
  logic reg_wr, reg_rd, irq_pin_one, irq_pin_two, event_pulse, irq, tr;
  logic inact = 1'b0, en = 1'b0, hp = 1'b0;
  int seed = 32'had7f_2564;
  int prev [3], qc, ac, th, mismatches, comparisons, cyc;
  int sq [6] = '{-16400, 16400, 16400, -16400, 16400, -16400};
  aid_host i_aid_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  aid_detector i_aid_detector (.clk, .rst, .sample_tick, .acc_x, .acc_y, .acc_z, .gyro_rate_in,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .accel_rate_out, .gyro_rate_out,
    .irq_pin_one, .irq_pin_two, .event_pulse, .irq);
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Mostly quiet samples, one in four loud
  function automatic int rv();
    return ($random(seed) & 3) ? $random(seed) % 2000 : $random(seed) % 30000;
  endfunction
  task automatic rchk(input logic [3:0] a);
    i_aid_host.rd(a, d);
    if (a == 4'h8) begin
      cmp("register", {4'h0, inact ? `AID_RATE_LOW : rt}, d);
    end else begin
      cmp("register", a == 4'h5 ? {3'h0, inact, 4'h0} : a == 4'h6 ? sts : rg[a], d);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] v);
    i_aid_host.wr(a, v);
    if (a < 4'h5 || a == 4'h7) rg[a] = v;
    if (a == 4'h6) sts = sts & ~v;
    rt = rg[0][7:4];
    th = rg[1][5:0] << (10 + rg[0][3:2]);
    en = rg[1][6];
    if (!en) begin
      inact = 1'b0;
      hp = 1'b0;
    end
  endtask
  task automatic tk(input int x, input int y, input int z);
    int v [3];
    int m;
    logic aq, an;
    v = '{x, y, z};
    @(posedge clk);
    sample_tick <= 1'b1;
    acc_x <= 16'(x);
    acc_y <= 16'(y);
    acc_z <= 16'(z);
    gyro_rate_in <= 4'($random(seed));
    @(posedge clk);
    sample_tick <= 1'b0;
    aq = 1'b1;
    an = 1'b0;
    foreach (v[i]) begin
      m = (v[i] - prev[i]) >>> 1;
      m = m < 0 ? -m : m;
      aq = aq & (m < th);
      an = an | (m > th);
    end
    qc = (en && hp && aq && !inact) ? qc + 1 : 0;
    ac = (en && hp && an && inact) ? ac + 1 : 0;
    tr = inact ? ac >= (rg[2][6:5] ? rg[2][6:5] : 1) : qc >= (rg[2][3:0] ? rg[2][3:0] * 512 : 1);
    if (tr) begin
      inact = !inact;
      sts = sts | (inact ? 8'h01 : 8'h02);
      qc = 0;
      ac = 0;
    end
    hp = en;
    prev = v;
    @(posedge clk);
    #1;
    cmp("rate", inact ? `AID_RATE_LOW : rt, accel_rate_out);
    cmp("pulse", tr, event_pulse);
    cmp("pin one", inact & rg[3][7], irq_pin_one);
    cmp("pin two", inact & rg[4][7], irq_pin_two);
    cmp("irq", |(sts & rg[7]), irq);
    cmp("gyro", gyro_rate_in, gyro_rate_out);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 10; a++) rchk(4'(a));
    $display("test reset done");
    w(4'h3, 8'h80);
    w(4'h5, 8'hff);
    for (int k = 0; k < 4; k++) begin
      w(4'h1, 8'h02);
      repeat (3) tk(rv(), rv(), rv());
      w(4'h0, {4'h5, 2'(k), 2'h0});
      w(4'h2, {1'b0, 2'(k), 5'h00});
      w(4'h4, {k[0], 7'h00});
      w(4'h7, 8'(k));
      w(4'h1, 8'h42);
      repeat (150) tk(rv(), rv(), rv());
      rchk(4'h5);
      rchk(4'h6);
      w(4'h6, 8'h03);
      rchk(4'h6);
      $display("test batch done");
    end
    for (int a = 0; a < 10; a++) rchk(4'(a));
    w(4'h1, 8'h02);
    w(4'h2, 8'h61);
    w(4'h1, 8'h42);
    repeat (301) tk(0, 0, 0);
    tk(-16384, 0, 0);
    tk(16384, 0, 0);
    repeat (512) tk(16384, 0, 0);
    foreach (sq[i]) tk(sq[i], 0, 0);
    $display("test durations done");
    end_sim();
  end
endmodule
